// ### hdl/pviu_cfg.svh
`ifndef PVIU_CFG_SVH
`define PVIU_CFG_SVH
// ------------------------------------------------------------
// Register offsets (byte addresses).
// ------------------------------------------------------------
`define PVIU_OFF_CTRL      8'h00
`define PVIU_OFF_ENABLE    8'h04
`define PVIU_OFF_PEND      8'h08
`define PVIU_OFF_PCLR      8'h0C
`define PVIU_OFF_ACCEPT    8'h10
`define PVIU_OFF_STATUS    8'h14
`define PVIU_OFF_VECTOR    8'h18
`define PVIU_OFF_IRQ_STAT  8'h1C
`define PVIU_OFF_IRQ_CLR   8'h20
`define PVIU_OFF_IRQ_EN    8'h24
// ------------------------------------------------------------
// Field positions and widths.
// ------------------------------------------------------------
`define PVIU_NSRC          39
`define PVIU_LO_SRC        2
`define PVIU_WDT_SRC       2
`define PVIU_EXT0_SRC      3
`define PVIU_ADC_SRC       38
`define PVIU_CTRL_IMF      0
`define PVIU_CTRL_EXT0     1
`define PVIU_CTRL_WDSEL    2
`define PVIU_ACC_SWI       6
`define PVIU_NEST_W        8
// ------------------------------------------------------------
// Vectors and reset values.
// ------------------------------------------------------------
`define PVIU_VEC_RESET     20'hFFFFC
`define PVIU_VEC_SWI       20'hFFFF8
`define PVIU_VEC_LOW_BASE  20'hFFFFC
`define PVIU_VEC_HI_BASE   20'hFFFBC
`define PVIU_HI_FIRST      32
`define PVIU_RST_CTRL      3'h4
`define PVIU_SRC_MASK      39'h7FFFFFFFFC
`define PVIU_RSVD_MASK     39'h2012AA6A90
`define PVIU_IRQ_W         3
`endif

// ### hdl/pviu_pkg.sv
package pviu_pkg;
   typedef logic [19:0] pviu_vec_t;
   typedef enum logic [1:0] {
      PVIU_EV_ACCEPT,
      PVIU_EV_RETURN,
      PVIU_EV_SWI
   } pviu_event_t;
endpackage

// ### hdl/pviu_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Three-stage synchroniser with agreement on the last two stages.
// ------------------------------------------------------------
module pviu_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   assign q_nxt = (s2_r & s3_r) | (q_r & (s2_r | s3_r));
   assign q_o   = q_r;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_r  <= '0;
      end else begin
         s1_r <= d_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r  <= q_nxt;
      end
   end
endmodule
`default_nettype wire

// ### hdl/pviu_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "pviu_cfg.svh"
// How it works
// (RULE_01) Twenty-four live sources plus reset, each with its own vector, sit in slots 2 to 38.
// (RULE_02) Software and watchdog interrupts ignore the master and per-source enables.
// (RULE_03) A request from a source sets its pending latch, which asks the core for service.
// (RULE_04) A maskable request wins only with master enable and its own enable both set.
// (RULE_05) External interrupt zero also needs its pin enable and vectors to FFFF0.
// (RULE_06) Priority is reset, software, watchdog, then rising slot index, converter last.
// (RULE_07) Of the two non-maskable factors, software takes priority over the watchdog.
// (RULE_08) Maskable vectors step down by four, FFFF0 to FFF80, then FFF3C to FFF24.
// (RULE_09) After reset the start vector at the top of memory is presented first.
// (RULE_10) Software clears the watchdog output select bit before using the watchdog interrupt.
// (RULE_11) Any reset clears master enable.
// (RULE_12) Any reset clears the nesting count.
// (RULE_13) Acceptance clears the pending latch, latches reset to zero, writes never set one.
// (RULE_14) Acceptance stacks master enable then clears it; the maskable return sets it.
// (RULE_15) All source enables reset to zero.
// (RULE_16) Reserved slots keep latch, enable and vector but no event ever sets them.
// (RULE_17) Each cycle the best qualifying vector is shown, and the request drops if none.
module pviu_top (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic             wb_ack_o,
   input  wire logic [38:0] src_req_i,
   input  wire logic        ext0_pin_i,
   input  wire logic        cpu_ack_i,
   input  wire logic        cpu_maskable_return_instruction_i,
   input  wire logic        cpu_retn_i,
   output logic             int_req_o,
   output logic [19:0]      int_vec_o,
   output logic             int_nmi_o,
   output logic             stack_imf_o,
   output logic             wdt_reset_req_o,
   output logic             irq_o
);
   // ------------------------------------------------------------
   // State.
   // ------------------------------------------------------------
   logic [38:0]            pending_latch_r;
   logic [38:0]            source_int_enable_r;
   logic                   master_int_enable_r;
   logic                   ext0_pin_enable_r;
   logic                   watchdog_output_select_r;
   logic [`PVIU_NEST_W-1:0] nesting_flag_r;
   logic                   swi_r;
   logic                   start_r;
   logic [38:0]            src_d1_r;
   logic [2:0]             irq_stat_r;
   logic [2:0]             irq_en_r;
   logic                   ext0_pin_s;
   logic                   int_req_r;
   logic [19:0]            int_vec_r;
   logic                   int_nmi_r;
   logic                   stack_imf_r;
   logic                   wdt_rst_r;
   logic                   irq_r;
   logic                   ack_r;
   logic [31:0]            dat_r;

   pviu_sync #(
      .W(1)
   ) u_ext0 (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i  (ext0_pin_i),
      .q_o  (ext0_pin_s)
   );

   // ------------------------------------------------------------
   // Bus decode.
   // ------------------------------------------------------------
   wire        bus_go   = wb_cyc_i & wb_stb_i & ~ack_r;
   wire        wr       = wb_cyc_i & wb_stb_i & ack_r & wb_we_i;
   wire [7:0]  adr      = wb_adr_i[7:0];
   wire        hit_ctrl = adr == `PVIU_OFF_CTRL;
   wire        hit_enl  = adr == `PVIU_OFF_ENABLE;
   wire        hit_pcl  = adr == `PVIU_OFF_PCLR;
   wire        hit_acc  = adr == `PVIU_OFF_ACCEPT;
   wire        hit_icl  = adr == `PVIU_OFF_IRQ_CLR;
   wire        hit_ien  = adr == `PVIU_OFF_IRQ_EN;
   wire [31:0] be       = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [31:0] wdat     = wb_dat_i & be;
   // Enable register holds sources 3..31 in bits 3..31; high sources 32..38 live in CTRL 14:8.
   wire        wr_ctrl  = wr & hit_ctrl;
   wire        wr_enl   = wr & hit_enl;
   wire        wr_pcl   = wr & hit_pcl;
   wire        swi_wr   = wr & hit_acc & wdat[`PVIU_ACC_SWI];

   // ------------------------------------------------------------
   // Source capture and priority select.
   // ------------------------------------------------------------
   wire [38:0] src_rise = src_req_i & ~src_d1_r & `PVIU_SRC_MASK & ~`PVIU_RSVD_MASK; // RULE_01 RULE_16
   wire [38:0] wdt_gate = {36'h0, ~watchdog_output_select_r, 2'b00};
   wire [38:0] set_vec  = src_rise & ~({36'h0, watchdog_output_select_r, 2'b00} & ~wdt_gate);
   wire [38:0] mask_ok  = source_int_enable_r & {39{master_int_enable_r}} &
                          ~{35'h0, ~(ext0_pin_enable_r & ext0_pin_s), 3'b000}; // RULE_04 RULE_05
   wire [38:0] qual     = pending_latch_r & (mask_ok | 39'h4); // RULE_02
   wire        nmi_any  = swi_r | qual[`PVIU_WDT_SRC];
   logic [5:0] win_idx;
   logic       win_any;

   always_comb begin
      win_idx = 6'h00;
      win_any = 1'b0;
      for (int i = `PVIU_NSRC - 1; i >= `PVIU_LO_SRC; i--) begin
         if (qual[i]) begin
            win_idx = 6'(i); // RULE_06
            win_any = 1'b1;
         end
      end
   end

   wire [19:0] vec_lo  = `PVIU_VEC_LOW_BASE - {12'h0, win_idx, 2'b00};
   wire [19:0] vec_hi  = `PVIU_VEC_HI_BASE - {12'h0, win_idx, 2'b00};
   wire [19:0] vec_src = (win_idx >= 6'(`PVIU_HI_FIRST)) ? vec_hi : vec_lo; // RULE_08
   // Software interrupt pre-empts hardware requests; it and the watchdog are non-maskable.
   wire [19:0] vec_nxt = start_r ? `PVIU_VEC_RESET : (swi_r ? `PVIU_VEC_SWI : vec_src); // RULE_09
   wire        req_nxt = start_r | swi_r | win_any; // RULE_17
   wire        take    = cpu_ack_i & int_req_r & (int_vec_r != `PVIU_VEC_RESET);
   wire        take_sw = take & swi_r;
   wire [38:0] clr_acc = (take & ~take_sw) ? (39'h1 << win_idx) : 39'h0;
   wire [38:0] clr_sw  = wr_pcl ? {7'h0, ~wdat} : 39'h0;
   wire [38:0] pend_nxt = (pending_latch_r & ~clr_acc & ~clr_sw) | set_vec; // RULE_03 RULE_13
   wire [2:0]  ev      = {swi_wr, cpu_maskable_return_instruction_i | cpu_retn_i, take};
   wire [2:0]  ist_nxt = (irq_stat_r & ~(wr & hit_icl ? wdat[2:0] : 3'h0)) | ev;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pending_latch_r <= 39'h0; // RULE_13
         src_d1_r        <= 39'h0;
         swi_r           <= 1'b0;
         start_r         <= 1'b1; // RULE_09
      end else begin
         pending_latch_r <= pend_nxt;
         src_d1_r        <= src_req_i;
         swi_r           <= (swi_r & ~take_sw) | swi_wr; // RULE_07
         start_r         <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         master_int_enable_r      <= 1'b0; // RULE_11
         source_int_enable_r      <= 39'h0; // RULE_15
         ext0_pin_enable_r        <= 1'b0;
         watchdog_output_select_r <= 1'b1; // RULE_10
         nesting_flag_r           <= '0; // RULE_12
      end else begin
         if (take) begin
            master_int_enable_r <= 1'b0; // RULE_14
         end else if (cpu_maskable_return_instruction_i) begin
            master_int_enable_r <= 1'b1; // RULE_14
         end else if (cpu_retn_i) begin
            master_int_enable_r <= stack_imf_r;
         end else if (wr_ctrl & wb_sel_i[0]) begin
            master_int_enable_r <= wb_dat_i[`PVIU_CTRL_IMF];
         end
         if (wr_ctrl & wb_sel_i[0]) begin
            ext0_pin_enable_r        <= wb_dat_i[`PVIU_CTRL_EXT0];
            watchdog_output_select_r <= wb_dat_i[`PVIU_CTRL_WDSEL];
         end
         if (wr_ctrl & wb_sel_i[1]) begin
            source_int_enable_r[38:32] <= wb_dat_i[14:8];
         end
         if (wr_enl) begin
            source_int_enable_r[31:3] <= (source_int_enable_r[31:3] & ~be[31:3]) | wdat[31:3];
         end
         if (take & ~(cpu_maskable_return_instruction_i | cpu_retn_i)) begin
            nesting_flag_r <= nesting_flag_r + 8'h01;
         end else if (~take & (cpu_maskable_return_instruction_i | cpu_retn_i)) begin
            nesting_flag_r <= nesting_flag_r - 8'h01;
         end
      end
   end

   // ------------------------------------------------------------
   // Outputs and bus answer.
   // ------------------------------------------------------------
   logic [31:0] rd_mux;

   always_comb begin
      case (adr)
         `PVIU_OFF_CTRL:     rd_mux = {17'h0, source_int_enable_r[38:32], 5'h0,
                                       watchdog_output_select_r, ext0_pin_enable_r,
                                       master_int_enable_r};
         `PVIU_OFF_ENABLE:   rd_mux = {source_int_enable_r[31:3], 3'h0};
         `PVIU_OFF_PEND:     rd_mux = pending_latch_r[31:0];
         `PVIU_OFF_STATUS:   rd_mux = {16'h0, nesting_flag_r, 1'b0, pending_latch_r[38:32]};
         `PVIU_OFF_VECTOR:   rd_mux = {11'h0, int_req_r, int_vec_r};
         `PVIU_OFF_IRQ_STAT: rd_mux = {29'h0, irq_stat_r};
         `PVIU_OFF_IRQ_EN:   rd_mux = {29'h0, irq_en_r};
         default:            rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r       <= 1'b0;
         dat_r       <= 32'h0;
         irq_stat_r  <= 3'h0;
         irq_en_r    <= 3'h0;
         irq_r       <= 1'b0;
         int_req_r   <= 1'b0;
         int_vec_r   <= `PVIU_VEC_RESET;
         int_nmi_r   <= 1'b0;
         stack_imf_r <= 1'b0;
         wdt_rst_r   <= 1'b0;
      end else begin
         ack_r      <= bus_go;
         dat_r      <= bus_go & ~wb_we_i ? rd_mux : 32'h0;
         irq_stat_r <= ist_nxt;
         if (wr & hit_ien) begin
            irq_en_r <= wdat[2:0];
         end
         irq_r     <= |(ist_nxt & irq_en_r);
         int_req_r <= req_nxt; // RULE_17
         int_vec_r <= vec_nxt;
         int_nmi_r <= swi_r | (win_idx == 6'(`PVIU_WDT_SRC) & win_any);
         if (take) begin
            stack_imf_r <= master_int_enable_r; // RULE_14
         end
         wdt_rst_r <= src_rise[`PVIU_WDT_SRC] & watchdog_output_select_r;
      end
   end

   assign wb_ack_o        = ack_r;
   assign wb_dat_o        = dat_r;
   assign irq_o           = irq_r;
   assign int_req_o       = int_req_r;
   assign int_vec_o       = int_vec_r;
   assign int_nmi_o       = int_nmi_r;
   assign stack_imf_o     = stack_imf_r;
   assign wdt_reset_req_o = wdt_rst_r;

   // ------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------
   property p_mask_block;
      @(posedge clk_i) disable iff (rst_i)
      (!master_int_enable_r && !swi_r && !pending_latch_r[`PVIU_WDT_SRC] && !start_r)
         |=> !int_req_r;
   endproperty
   a_mask_block: assert property (p_mask_block) else $error("masked request shown"); // RULE_04

   property p_accept_clears;
      @(posedge clk_i) disable iff (rst_i)
      (take && !take_sw && !set_vec[win_idx]) |=> !pending_latch_r[$past(win_idx)];
   endproperty
   a_accept_clears: assert property (p_accept_clears) else $error("latch kept"); // RULE_13

   property p_accept_imf;
      @(posedge clk_i) disable iff (rst_i)
      take |=> !master_int_enable_r && stack_imf_r == $past(master_int_enable_r);
   endproperty
   a_accept_imf: assert property (p_accept_imf) else $error("enable not stacked"); // RULE_14

   property p_maskable_return_instruction;
      @(posedge clk_i) disable iff (rst_i)
      (cpu_maskable_return_instruction_i && !take) |=> master_int_enable_r;
   endproperty
   a_maskable_return_instruction: assert property (p_maskable_return_instruction) else $error("return left enable off"); // RULE_14

   property p_rsvd;
      @(posedge clk_i) disable iff (rst_i)
      !(|(pending_latch_r & `PVIU_RSVD_MASK));
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved slot set"); // RULE_16

   sequence s_reset_release;
      $fell(rst_i);
   endsequence

   sequence s_start_shown;
      ##1 int_req_r && int_vec_r == `PVIU_VEC_RESET;
   endsequence

   property p_start;
      @(posedge clk_i) s_reset_release |-> s_start_shown;
   endproperty
   a_start: assert property (p_start) else $error("no start vector"); // RULE_09

   property p_reset_clear;
      @(posedge clk_i) $fell(rst_i) |-> !master_int_enable_r && nesting_flag_r == 0
         && source_int_enable_r == 0 && pending_latch_r == 0;
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong"); // RULE_11

   property p_wdt_nmi;
      @(posedge clk_i) disable iff (rst_i)
      (pending_latch_r[`PVIU_WDT_SRC] && !swi_r && !start_r) |=> int_req_r
         && int_vec_r == 20'hFFFF4;
   endproperty
   a_wdt_nmi: assert property (p_wdt_nmi) else $error("watchdog not shown"); // RULE_02

   property p_ext0_pin;
      @(posedge clk_i) disable iff (rst_i)
      (!ext0_pin_s && !swi_r && !start_r && (pending_latch_r & ~39'h8) == 39'h0)
         |=> !int_req_r;
   endproperty
   a_ext0_pin: assert property (p_ext0_pin) else $error("pin blocked request shown"); // RULE_05
endmodule
`default_nettype wire

// ### bench/pviu_core_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Core side: takes the shown request after a chosen delay.
// ------------------------------------------------------------
module pviu_core_model (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                int_req_i,
   input  wire pviu_pkg::pviu_vec_t int_vec_i,
   input  wire logic                int_nmi_i,
   input  wire logic                en_i,
   input  wire logic [3:0]          delay_i,
   output logic                     cpu_ack_o,
   output pviu_pkg::pviu_vec_t      taken_vec_o,
   output logic                     taken_nmi_o,
   output logic [7:0]               taken_cnt_o
);
   logic [3:0] wait_r;
   logic [1:0] gap_r;
   // The gap keeps a second take off the stale request of the last one.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_ack_o   <= 1'b0;
         taken_vec_o <= 20'h00000;
         taken_nmi_o <= 1'b0;
         taken_cnt_o <= 8'h00;
         wait_r      <= 4'h0;
         gap_r       <= 2'h0;
      end else begin
         cpu_ack_o <= 1'b0;
         if (cpu_ack_o) begin
            if (int_req_i) begin
               taken_vec_o <= int_vec_i;
               taken_nmi_o <= int_nmi_i;
               taken_cnt_o <= taken_cnt_o + 8'h01;
            end
            gap_r  <= 2'h3;
            wait_r <= 4'h0;
         end else if (gap_r != 2'h0) begin
            gap_r <= gap_r - 2'h1;
         end else if (en_i && int_req_i) begin
            if (wait_r == delay_i) cpu_ack_o <= 1'b1;
            else wait_r <= wait_r + 4'h1;
         end else begin
            wait_r <= 4'h0;
         end
      end
   end
endmodule
`default_nettype wire

// ### bench/test_prioritized_vectored_interrupt_unit.sv
`timescale 1ns/1ns
`default_nettype none
module test_prioritized_vectored_interrupt_unit;
   localparam logic [38:0] RSVD = 39'h20_12AA_6A90;
   localparam logic [38:0] LIVE = 39'h7F_FFFF_FFF8 & ~RSVD;
   logic        clk, rst, we, cyc, stb, ack, ext0, maskable_return_instruction, retn, req, nmi, simf, wdt, irq;
   logic        cack, men, tnmi, wdt_seen;
   logic [3:0]  sel, mdly;
   logic [31:0] adr, wdat, rdat, d;
   logic [38:0] src;
   logic [19:0] vec, tvec;
   logic [7:0]  tcnt;
   int          failures, checked, k;

   pviu_top u_dut (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_ack_o(ack), .src_req_i(src), .ext0_pin_i(ext0), .cpu_ack_i(cack),
      .cpu_maskable_return_instruction_i(maskable_return_instruction), .cpu_retn_i(retn), .int_req_o(req), .int_vec_o(vec),
      .int_nmi_o(nmi), .stack_imf_o(simf), .wdt_reset_req_o(wdt), .irq_o(irq));
   pviu_core_model u_core (.clk_i(clk), .rst_i(rst), .int_req_i(req), .int_vec_i(vec),
      .int_nmi_i(nmi), .en_i(men), .delay_i(mdly), .cpu_ack_o(cack),
      .taken_vec_o(tvec), .taken_nmi_o(tnmi), .taken_cnt_o(tcnt));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) begin
      if (rst) wdt_seen <= 1'b0;
      else if (wdt === 1'b1) wdt_seen <= 1'b1;
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v,
                      output logic [31:0] r);
      int n;
      n = 0;
      adr <= {24'h000000, a};
      wdat <= v;
      we <= w;
      sel <= 4'hF;
      cyc <= 1'b1;
      stb <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      r = rdat;
      chk("bus ack", 32'h1, {31'h0, ack});
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string n);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(n, e, r);
   endtask
   task automatic pulse_src(input logic [38:0] m);
      src <= m;
      @(posedge clk);
      src <= 39'h0;
      @(posedge clk);
   endtask
   task automatic ret_pulse(input logic maskable);
      if (maskable) maskable_return_instruction <= 1'b1;
      else retn <= 1'b1;
      @(posedge clk);
      maskable_return_instruction <= 1'b0;
      retn <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_take(input logic [7:0] n);
      for (int i = 0; i < 200 && tcnt !== n; i++) @(posedge clk);
      chk("taken count", {24'h0, n}, {24'h0, tcnt});
   endtask
   function automatic logic [31:0] exp_vec(input int s);
      if (s < 32) return 32'h000F_FFFC - 32'(4 * s);
      return 32'h000F_FF3C - 32'(4 * (s - 32));
   endfunction
   task automatic conclude();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      #(4 * 20000);
      failures++;
      conclude();
   end

   initial begin
      failures = 0;
      checked = 0;
      rst = 1'b1;
      {we, cyc, stb, maskable_return_instruction, retn, men} = 6'h00;
      ext0 = 1'b1;
      sel = 4'h0;
      mdly = 4'h0;
      adr = 32'h0;
      wdat = 32'h0;
      src = 39'h0;
      repeat (2) @(posedge clk);
      chk("req in reset", 32'h0, {31'h0, req});
      chk("vector in reset", 32'h000F_FFFC, {12'h0, vec});
      rst <= 1'b0;
      d = 32'h0;
      repeat (3) begin
         @(posedge clk);
         if (req === 1'b1 && vec === 20'hFFFFC) d = 32'h1;
      end
      chk("start vector", 32'h1, d);
      repeat (3) @(posedge clk);
      chk("req idle", 32'h0, {31'h0, req});
      rdc(8'h00, 32'h0000_0004, "control");
      rdc(8'h04, 32'h0, "enables");
      rdc(8'h08, 32'h0, "pending");
      rdc(8'h14, 32'h0, "status");
      rdc(8'h30, 32'h0, "unmapped");
      bus(1'b1, 8'h30, 32'hFFFF_FFFF, d);
      pulse_src({39{1'b1}});
      repeat (2) @(posedge clk);
      chk("watchdog reset", 32'h1, {31'h0, wdt_seen});
      rdc(8'h08, LIVE[31:0], "pending");
      rdc(8'h14, {25'h0, LIVE[38:32]}, "status");
      bus(1'b1, 8'h04, 32'hFFFF_FFFF, d);
      bus(1'b1, 8'h00, 32'h0000_7F02, d);
      repeat (2) @(posedge clk);
      chk("masked req", 32'h0, {31'h0, req});
      men <= 1'b1;
      bus(1'b1, 8'h00, 32'h0000_7F03, d);
      k = 0;
      for (int s = 3; s < 39; s++) begin
         if (LIVE[s]) begin
            k++;
            wait_take(8'(k));
            chk("vector", exp_vec(s), {12'h0, tvec});
            if (k == 1) begin
               rdc(8'h00, 32'h0000_7F02, "control after take");
               chk("stacked enable", 32'h1, {31'h0, simf});
               chk("maskable flag", 32'h0, {31'h0, tnmi});
               rdc(8'h14, {16'h0, 8'h01, 1'b0, LIVE[38:32]}, "nesting");
            end
            ret_pulse(1'b1);
         end
      end
      chk("accepted", 32'h17, {24'h0, tcnt});
      rdc(8'h08, 32'h0, "pending drained");
      rdc(8'h14, 32'h0, "status drained");
      chk("req dropped", 32'h0, {31'h0, req});
      bus(1'b1, 8'h00, 32'h0000_7F02, d);
      men <= 1'b0;
      bus(1'b1, 8'h10, 32'h0000_0040, d);
      pulse_src(39'h4);
      men <= 1'b1;
      mdly <= 4'h5;
      wait_take(8'h18);
      chk("software vector", 32'h000F_FFF8, {12'h0, tvec});
      chk("nmi flag", 32'h1, {31'h0, tnmi});
      wait_take(8'h19);
      chk("watchdog vector", 32'h000F_FFF4, {12'h0, tvec});
      chk("watchdog nmi flag", 32'h1, {31'h0, tnmi});
      ret_pulse(1'b0);
      ret_pulse(1'b0);
      rdc(8'h00, 32'h0000_7F02, "control after nmi");
      rdc(8'h1C, 32'h7, "event status");
      chk("irq masked", 32'h0, {31'h0, irq});
      bus(1'b1, 8'h24, 32'h1, d);
      repeat (2) @(posedge clk);
      chk("irq raised", 32'h1, {31'h0, irq});
      bus(1'b1, 8'h20, 32'h7, d);
      rdc(8'h1C, 32'h0, "event cleared");
      chk("irq cleared", 32'h0, {31'h0, irq});
      men <= 1'b0;
      pulse_src(39'h20);
      repeat (2) @(posedge clk);
      rdc(8'h08, 32'h20, "latch set");
      bus(1'b1, 8'h0C, 32'hFFFF_FFDF, d);
      rdc(8'h08, 32'h0, "latch cleared");
      bus(1'b1, 8'h0C, 32'hFFFF_FFFF, d);
      rdc(8'h08, 32'h0, "latch not set");
      ext0 <= 1'b0;
      pulse_src(39'h8);
      bus(1'b1, 8'h00, 32'h0000_7F03, d);
      repeat (6) @(posedge clk);
      chk("pin blocked", 32'h0, {31'h0, req});
      ext0 <= 1'b1;
      repeat (6) @(posedge clk);
      rdc(8'h18, 32'h001F_FFF0, "pin vector");
      conclude();
   end
endmodule
`default_nettype wire
